// >>> rtl/sfesp_core.sv
// Erase, suspend/resume and power-down command sequencer of the serial flash
`timescale 1ns/1ns
`default_nettype none
module sfesp_core
  import sfesp_pkg::*;
#(
  parameter int unsigned SECTOR_ERASE_CYC = 500000,
  parameter int unsigned BLK32_ERASE_CYC  = 1500000,
  parameter int unsigned BLK64_ERASE_CYC  = 2000000,
  parameter int unsigned CHIP_ERASE_CYC   = 100000000,
  parameter int unsigned PROG_CYC         = 5000
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  // Serial link pins
  input  wire logic        SPI_CS_N_I,
  input  wire logic        SPI_SCK_I,
  input  wire logic        SPI_DI_I,
  output logic             SPI_DO_O,
  output logic             SPI_DO_OE_N_O,
  // Configuration and protection lookup
  input  wire logic        ADDR4_MODE_I,
  input  wire logic        TARGET_PROTECTED_I,
  input  wire logic        ANY_PROTECTED_I,
  output logic [31:0]      CMD_ADDR_O,
  output logic [2:0]       CMD_KIND_O,
  // Write enable and program requests from sibling logic
  input  wire logic        WEL_SET_I,
  input  wire logic        PROG_START_I,
  // Status
  output logic             BUSY_O,
  output logic             HALT_PENDING_O,
  output logic             WRITE_ENABLE_LATCH_O,
  output logic             POWER_DOWN_O,
  // Suspend lockouts for sibling decoders
  output logic             WRSR_INHIBIT_O,
  output logic             ERASE_INHIBIT_O,
  output logic             PROG_INHIBIT_O,
  // Array update
  output logic             COMMIT_O,
  output logic [2:0]       COMMIT_KIND_O,
  output logic [31:0]      COMMIT_ADDR_O
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_SUSPENDING, ST_SUSPENDED, ST_RESUMING, ST_PD_ENTER, ST_PD, ST_PD_EXIT
  } sfesp_state_t;

  logic         cs_n_s;
  logic         cs_fall;
  logic         cs_rise;
  logic         sck_rise;
  logic         sck_fall;
  logic         di_s;

  logic [2:0]   bit_cnt_reg;
  logic [2:0]   byte_cnt_reg;
  logic [6:0]   rx_reg;
  logic [7:0]   opcode_reg;
  logic [31:0]  addr_reg;
  logic [7:0]   out_sr_reg;
  logic         out_active_reg;
  logic         do_reg;

  sfesp_state_t state_reg;
  logic [2:0]   kind_reg;
  logic [31:0]  target_reg;
  logic [31:0]  op_cnt_reg;
  logic [15:0]  wait_cnt_reg;
  logic         halt_reg;
  logic         wel_reg;
  logic         commit_reg;

  logic         byte_done;
  logic [7:0]   new_byte;
  logic         in_pd;
  logic         aligned;
  logic         one_byte;
  logic [2:0]   cmd_kind;
  logic         prot_hit;
  logic         erase_ok;
  logic         susp_ok;
  logic         resume_ok;
  logic         pd_ok;
  logic         release_ok;
  logic         prog_ok;
  logic [7:0]   status_byte;
  logic         load_status;
  logic         load_id;

  sfesp_link_sync u_sync (
    .clk_i      (REF_CLK_I),
    .rstn_i     (RSTN_I),
    .cs_n_i     (SPI_CS_N_I),
    .sck_i      (SPI_SCK_I),
    .di_i       (SPI_DI_I),
    .cs_n_o     (cs_n_s),
    .cs_fall_o  (cs_fall),
    .cs_rise_o  (cs_rise),
    .sck_rise_o (sck_rise),
    .sck_fall_o (sck_fall),
    .di_o       (di_s)
  );

  assign byte_done = sck_rise & ~cs_n_s & (bit_cnt_reg == BITS_LAST);
  assign new_byte  = {rx_reg, di_s};
  assign in_pd     = (state_reg == ST_PD_ENTER) | (state_reg == ST_PD) | (state_reg == ST_PD_EXIT);

  // Frame capture: opcode, then address bytes shifted in MSB first
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      rx_reg       <= 7'h00;
      opcode_reg   <= 8'h00;
      addr_reg     <= 32'h0000_0000;
    end else if (cs_fall) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      opcode_reg   <= 8'h00;
      addr_reg     <= 32'h0000_0000;
    end else if (sck_rise && !cs_n_s) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= new_byte[6:0];
      if (byte_done) begin
        if (byte_cnt_reg != BYTES_SAT) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        if (byte_cnt_reg == 3'h0) begin
          opcode_reg <= new_byte;
        end else if (byte_cnt_reg <= BYTES_ADDR4) begin
          addr_reg <= {addr_reg[23:0], new_byte};
        end
      end
    end
  end

  // Command qualification at chip select rise
  assign aligned  = (bit_cnt_reg == 3'h0);
  assign one_byte = aligned & (byte_cnt_reg == BYTES_OP);
  assign cmd_kind = erase_kind(opcode_reg);
  assign prot_hit = (cmd_kind == KIND_CHIP) ? ANY_PROTECTED_I : TARGET_PROTECTED_I;

  // Only an idle device starts an erase, so suspended states refuse every erase opcode
  assign erase_ok = cs_rise & (state_reg == ST_IDLE) & (cmd_kind != KIND_NONE)
                  & wel_reg
                  & aligned
                  & (byte_cnt_reg == BYTES_OP + addr_bytes(opcode_reg, ADDR4_MODE_I))
                  & ~prot_hit;
  assign susp_ok    = cs_rise & one_byte & (opcode_reg == OP_SUSPEND)
                    & (state_reg == ST_RUN) & ~halt_reg & (kind_reg != KIND_CHIP);
  assign resume_ok  = cs_rise & one_byte & (opcode_reg == OP_RESUME)
                    & (state_reg == ST_SUSPENDED) & halt_reg;
  assign pd_ok      = cs_rise & one_byte & (opcode_reg == OP_POWER_DOWN) & (state_reg == ST_IDLE);
  assign release_ok = cs_rise & one_byte & (opcode_reg == OP_RELEASE) & (state_reg == ST_PD);
  assign prog_ok    = PROG_START_I & (state_reg == ST_IDLE) & wel_reg & ~erase_ok & ~pd_ok;

  // Sequencer; the erase timer holds its count across a suspend
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg    <= ST_IDLE;
      kind_reg     <= KIND_NONE;
      target_reg   <= 32'h0000_0000;
      op_cnt_reg   <= 32'h0000_0000;
      wait_cnt_reg <= 16'h0000;
      commit_reg   <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (erase_ok) begin
            state_reg <= ST_RUN;
            kind_reg  <= cmd_kind;
            case (cmd_kind)
              KIND_SECTOR: begin
                target_reg <= addr_reg & MASK_SECTOR;
                op_cnt_reg <= SECTOR_ERASE_CYC;
              end
              KIND_BLK32: begin
                target_reg <= addr_reg & MASK_BLK32;
                op_cnt_reg <= BLK32_ERASE_CYC;
              end
              KIND_BLK64: begin
                target_reg <= addr_reg & MASK_BLK64;
                op_cnt_reg <= BLK64_ERASE_CYC;
              end
              default: begin
                target_reg <= MASK_CHIP;
                op_cnt_reg <= CHIP_ERASE_CYC;
              end
            endcase
          end else if (prog_ok) begin
            state_reg  <= ST_RUN;
            kind_reg   <= KIND_PROG;
            target_reg <= 32'h0000_0000;
            op_cnt_reg <= PROG_CYC;
          end else if (pd_ok) begin
            state_reg    <= ST_PD_ENTER;
            wait_cnt_reg <= DP_CYC;
          end
        end
        ST_RUN: begin
          if (susp_ok) begin
            state_reg    <= ST_SUSPENDING;
            wait_cnt_reg <= SUS_CYC;
          end else if (op_cnt_reg <= 32'h0000_0001) begin
            state_reg  <= ST_IDLE;
            commit_reg <= 1'b1;
          end else begin
            op_cnt_reg <= op_cnt_reg - 32'h0000_0001;
          end
        end
        ST_SUSPENDING: begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg <= 16'h0001) begin
            state_reg <= ST_SUSPENDED;
          end
        end
        ST_SUSPENDED: begin
          if (resume_ok) begin
            state_reg    <= ST_RESUMING;
            wait_cnt_reg <= RESUME_CYC;
          end
        end
        ST_RESUMING: begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg <= 16'h0001) begin
            state_reg <= ST_RUN;
          end
        end
        ST_PD_ENTER: begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg <= 16'h0001) begin
            state_reg <= ST_PD;
          end
        end
        ST_PD: begin
          if (release_ok) begin
            state_reg    <= ST_PD_EXIT;
            wait_cnt_reg <= REST_CYC;
          end
        end
        ST_PD_EXIT: begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg <= 16'h0001) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Halt flag: set and cleared on the very edge the command is taken
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      halt_reg <= 1'b0;
    end else if (susp_ok) begin
      halt_reg <= 1'b1;
    end else if (resume_ok) begin
      halt_reg <= 1'b0;
    end
  end

  // Write enable latch; a set arriving with the completion clear wins
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wel_reg <= 1'b0;
    end else if (WEL_SET_I) begin
      wel_reg <= 1'b1;
    end else if (commit_reg) begin
      wel_reg <= 1'b0;
    end
  end

  // Read-back: status and ID bytes are reloaded each byte so they stay current
  assign status_byte = {halt_reg, 5'h00, wel_reg, BUSY_O} & 8'hFF;
  assign load_status = byte_done & ~in_pd
                     & (((byte_cnt_reg == 3'h0) & (new_byte == OP_READ_STATUS))
                     | ((byte_cnt_reg != 3'h0) & (opcode_reg == OP_READ_STATUS)));
  assign load_id     = byte_done & ~in_pd & (opcode_reg == OP_RELEASE)
                     & (byte_cnt_reg >= BYTES_DUMMY);

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      out_sr_reg     <= 8'h00;
      out_active_reg <= 1'b0;
      do_reg         <= 1'b0;
    end else if (cs_n_s) begin
      out_active_reg <= 1'b0;
    end else if (load_status) begin
      out_sr_reg     <= status_byte;
      out_active_reg <= 1'b1;
    end else if (load_id) begin
      out_sr_reg     <= DEVICE_ID;
      out_active_reg <= 1'b1;
    end else if (sck_fall && out_active_reg) begin
      do_reg     <= out_sr_reg[7];
      out_sr_reg <= {out_sr_reg[6:0], 1'b0};
    end
  end

  assign SPI_DO_O       = do_reg;
  assign SPI_DO_OE_N_O  = ~(out_active_reg & ~cs_n_s);

  assign CMD_ADDR_O     = addr_reg;
  assign CMD_KIND_O     = cmd_kind;

  // Busy and power-down flags decode straight from the state register; halt and write enable come from their own registers
  assign BUSY_O               = (state_reg == ST_RUN) | (state_reg == ST_SUSPENDING);
  assign HALT_PENDING_O       = halt_reg;
  assign WRITE_ENABLE_LATCH_O = wel_reg;
  assign POWER_DOWN_O         = in_pd;

  assign ERASE_INHIBIT_O = halt_reg & (kind_reg != KIND_PROG);
  assign PROG_INHIBIT_O  = halt_reg & (kind_reg == KIND_PROG);
  assign WRSR_INHIBIT_O  = halt_reg;

  assign COMMIT_O      = commit_reg;
  assign COMMIT_KIND_O = kind_reg;
  assign COMMIT_ADDR_O = target_reg;

endmodule : sfesp_core
`default_nettype wire

// >>> rtl/sfesp_link_sync.sv
// Link pin synchronisers and edge detection
`timescale 1ns/1ns
`default_nettype none
module sfesp_link_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Raw pins
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic di_i,
  // Synchronised view
  output logic      cs_n_o,
  output logic      cs_fall_o,
  output logic      cs_rise_o,
  output logic      sck_rise_o,
  output logic      sck_fall_o,
  output logic      di_o
);
  logic [2:0] cs_meta_reg;
  logic [2:0] sck_meta_reg;
  logic [1:0] di_meta_reg;

  // Stage 0 only feeds stage 1; edges compare stages 1 and 2
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_meta_reg  <= 3'h7;
      sck_meta_reg <= 3'h0;
      di_meta_reg  <= 2'h0;
    end else begin
      cs_meta_reg  <= {cs_meta_reg[1:0], cs_n_i};
      sck_meta_reg <= {sck_meta_reg[1:0], sck_i};
      di_meta_reg  <= {di_meta_reg[0], di_i};
    end
  end

  assign cs_n_o     = cs_meta_reg[1];
  assign cs_fall_o  = cs_meta_reg[2] & ~cs_meta_reg[1];
  assign cs_rise_o  = ~cs_meta_reg[2] & cs_meta_reg[1];
  assign sck_rise_o = ~sck_meta_reg[2] & sck_meta_reg[1];
  assign sck_fall_o = sck_meta_reg[2] & ~sck_meta_reg[1];
  assign di_o       = di_meta_reg[1];
endmodule : sfesp_link_sync
`default_nettype wire

// >>> rtl/sfesp_pkg.sv
// Constants, opcodes and timing for the erase/suspend/power-down sequencer
package sfesp_pkg;

  // Opcodes
  localparam logic [7:0] OP_SECT_ERASE   = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE4  = 8'h21;
  localparam logic [7:0] OP_BLK32_ERASE  = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE  = 8'hD8;
  localparam logic [7:0] OP_BLK64_ERASE4 = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND      = 8'h75;
  localparam logic [7:0] OP_RESUME       = 8'h7A;
  localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
  localparam logic [7:0] OP_RELEASE      = 8'hAB;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;

  // Operation kinds
  localparam logic [2:0] KIND_SECTOR = 3'h0;
  localparam logic [2:0] KIND_BLK32  = 3'h1;
  localparam logic [2:0] KIND_BLK64  = 3'h2;
  localparam logic [2:0] KIND_CHIP   = 3'h3;
  localparam logic [2:0] KIND_PROG   = 3'h4;
  localparam logic [2:0] KIND_NONE   = 3'h7;

  // Address bases for each erase size
  localparam logic [31:0] MASK_SECTOR = 32'hFFFF_F000;
  localparam logic [31:0] MASK_BLK32  = 32'hFFFF_8000;
  localparam logic [31:0] MASK_BLK64  = 32'hFFFF_0000;
  localparam logic [31:0] MASK_CHIP   = 32'h0000_0000;

  // Frame counts
  localparam logic [2:0] BITS_LAST   = 3'h7;
  localparam logic [2:0] BYTES_OP    = 3'h1;
  localparam logic [2:0] BYTES_ADDR3 = 3'h3;
  localparam logic [2:0] BYTES_ADDR4 = 3'h4;
  localparam logic [2:0] BYTES_DUMMY = 3'h3;
  localparam logic [2:0] BYTES_SAT   = 3'h7;

  // Status byte layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT  = 1;
  localparam int STAT_SUS_BIT  = 7;

  // Device ID answered by ABh; value is arbitrary
  localparam logic [7:0] DEVICE_ID = 8'h5A;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SUS_NS      = 20000;
  localparam int T_DP_NS       = 3000;
  localparam int T_REST_NS     = 3000;
  localparam int T_RESUME_NS   = 200;
  localparam logic [15:0] SUS_CYC    = 16'(T_SUS_NS / CLK_PERIOD_NS);
  localparam logic [15:0] DP_CYC     = 16'(T_DP_NS / CLK_PERIOD_NS);
  localparam logic [15:0] REST_CYC   = 16'((T_REST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RESUME_CYC = 16'(T_RESUME_NS / CLK_PERIOD_NS);

  // Address bytes an erase opcode carries; zero for chip erase
  function automatic logic [2:0] addr_bytes(input logic [7:0] op, input logic addr4);
    case (op)
      OP_SECT_ERASE4, OP_BLK64_ERASE4:                 addr_bytes = BYTES_ADDR4;
      OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE:   addr_bytes = addr4 ? BYTES_ADDR4 : BYTES_ADDR3;
      default:                                         addr_bytes = 3'h0;
    endcase
  endfunction : addr_bytes

  // Erase kind of an opcode, KIND_NONE for anything else
  function automatic logic [2:0] erase_kind(input logic [7:0] op);
    case (op)
      OP_SECT_ERASE, OP_SECT_ERASE4:     erase_kind = KIND_SECTOR;
      OP_BLK32_ERASE:                    erase_kind = KIND_BLK32;
      OP_BLK64_ERASE, OP_BLK64_ERASE4:   erase_kind = KIND_BLK64;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:  erase_kind = KIND_CHIP;
      default:                           erase_kind = KIND_NONE;
    endcase
  endfunction : erase_kind

endpackage : sfesp_pkg

// >>> testbench/sfesp_core_assertions.sv
// Concurrent checks on the ports of the erase, suspend and power-down sequencer
`timescale 1ns/1ns
`default_nettype none
module sfesp_chk
  import sfesp_pkg::*;
(
  // Clock and reset
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  // Watched ports
  input wire logic        SPI_DO_OE_N_O,
  input wire logic        WEL_SET_I,
  input wire logic        BUSY_O,
  input wire logic        HALT_PENDING_O,
  input wire logic        WRITE_ENABLE_LATCH_O,
  input wire logic        POWER_DOWN_O,
  input wire logic        WRSR_INHIBIT_O,
  input wire logic        ERASE_INHIBIT_O,
  input wire logic        PROG_INHIBIT_O,
  input wire logic        COMMIT_O,
  input wire logic [2:0]  COMMIT_KIND_O,
  input wire logic [31:0] COMMIT_ADDR_O
);
  // Margin over the suspend latency of 200 cycles
  localparam int SUS_MAX = 205;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  busy_commit_a: assert property (COMMIT_O |-> !BUSY_O && $past(BUSY_O))
    else $error("commit without a finished busy phase");
  commit_pulse_a: assert property (COMMIT_O |=> !COMMIT_O)
    else $error("commit held longer than one cycle");
  wel_clear_a: assert property (COMMIT_O && !WEL_SET_I |=> !WRITE_ENABLE_LATCH_O)
    else $error("write enable latch kept after completion");
  commit_align_a: assert property (COMMIT_O |->
      (COMMIT_ADDR_O & ~(COMMIT_KIND_O == KIND_SECTOR ? MASK_SECTOR : COMMIT_KIND_O == KIND_BLK32 ? MASK_BLK32 :
      COMMIT_KIND_O == KIND_BLK64 ? MASK_BLK64 : MASK_CHIP)) == 32'h0000_0000)
    else $error("commit base not aligned to its erase size");
  suspend_drop_a: assert property ($rose(HALT_PENDING_O) |-> ##[0:SUS_MAX] !BUSY_O)
    else $error("busy did not drop within suspend latency");
  resume_rise_a: assert property ($fell(HALT_PENDING_O) |-> ##[0:3] BUSY_O)
    else $error("busy did not return after resume");
  busy_unhalted_a: assert property ($rose(BUSY_O) |-> !HALT_PENDING_O)
    else $error("busy rose while suspended");
  wrsr_lock_a: assert property (WRSR_INHIBIT_O == HALT_PENDING_O)
    else $error("write status lockout differs from suspend flag");
  kind_lock_a: assert property ((ERASE_INHIBIT_O || PROG_INHIBIT_O) |->
      HALT_PENDING_O && !(ERASE_INHIBIT_O && PROG_INHIBIT_O))
    else $error("lockout without a single suspended operation");
  pd_silent_a: assert property (POWER_DOWN_O |-> SPI_DO_OE_N_O)
    else $error("output driven in power down");

  commit_c: cover property (COMMIT_O);
  suspend_c: cover property ($rose(HALT_PENDING_O));
  resume_c: cover property ($fell(HALT_PENDING_O));
  pd_c: cover property ($rose(POWER_DOWN_O));
endmodule : sfesp_chk

bind sfesp_core sfesp_chk u_chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .SPI_DO_OE_N_O(SPI_DO_OE_N_O),
  .WEL_SET_I(WEL_SET_I), .BUSY_O(BUSY_O), .HALT_PENDING_O(HALT_PENDING_O),
  .WRITE_ENABLE_LATCH_O(WRITE_ENABLE_LATCH_O), .POWER_DOWN_O(POWER_DOWN_O), .WRSR_INHIBIT_O(WRSR_INHIBIT_O),
  .ERASE_INHIBIT_O(ERASE_INHIBIT_O), .PROG_INHIBIT_O(PROG_INHIBIT_O), .COMMIT_O(COMMIT_O),
  .COMMIT_KIND_O(COMMIT_KIND_O), .COMMIT_ADDR_O(COMMIT_ADDR_O));
`default_nettype wire

// >>> testbench/sfesp_host_model.sv
// Host serial controller model that clocks frames into the sequencer
`timescale 1ns/1ns
`default_nettype none
module sfesp_host_model (
  // Clock
  input  wire logic clk_i,
  // Link
  input  wire logic do_i,
  output var  logic cs_n_o,
  output var  logic sck_o,
  output var  logic di_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    di_o   = 1'b0;
  end

  // Mode 0, MSB first, half period of 4 clocks; SCK stands low outside frames
  task automatic frame(input logic [63:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      di_o = d[63-i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      rx    = {rx[6:0], do_i};
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    // Released data line must not look like a held bit
    di_o   = ~di_o;
    repeat (4) @(negedge clk_i);
  endtask : frame
endmodule : sfesp_host_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the erase, suspend and power-down sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sfesp_pkg::*;
  localparam logic [7:0] OPS [7] = '{8'h20, 8'h21, 8'h52, 8'hD8, 8'hDC, 8'hC7, 8'h60};
  logic        clk = 1'b0, rstn = 1'b0, a4 = 1'b0, tprot = 1'b0, aprot = 1'b0, wel_set = 1'b0, prog = 1'b0;
  logic        cs_n, sck, di, do_o, oe_n, do_line, busy, halt, write_enable_latch, pd, einh, pinh, winh, commit;
  logic        do_hold = 1'b0;
  logic [2:0]  ckind, ckd;
  logic [31:0] caddr, cad;
  int          bad_count = 0, n_compared = 0, oe_cnt = 0;

  always #50 clk = ~clk;
  // Undriven data line shows the inverse of the last driven bit
  always @(posedge clk) if (!oe_n) do_hold <= do_o;
  always @(posedge clk) if (oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
  assign do_line = oe_n ? ~do_hold : do_o;

  sfesp_host_model u_host (.clk_i(clk), .do_i(do_line), .cs_n_o(cs_n), .sck_o(sck), .di_o(di));
  sfesp_core #(.SECTOR_ERASE_CYC(1500), .BLK32_ERASE_CYC(60), .BLK64_ERASE_CYC(60), .CHIP_ERASE_CYC(1000),
    .PROG_CYC(400)) dut (.REF_CLK_I(clk), .RSTN_I(rstn), .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck), .SPI_DI_I(di),
    .SPI_DO_O(do_o), .SPI_DO_OE_N_O(oe_n), .ADDR4_MODE_I(a4), .TARGET_PROTECTED_I(tprot),
    .ANY_PROTECTED_I(aprot), .CMD_ADDR_O(cad), .CMD_KIND_O(ckd), .WEL_SET_I(wel_set), .PROG_START_I(prog),
    .BUSY_O(busy), .HALT_PENDING_O(halt), .WRITE_ENABLE_LATCH_O(write_enable_latch), .POWER_DOWN_O(pd),
    .WRSR_INHIBIT_O(winh), .ERASE_INHIBIT_O(einh), .PROG_INHIBIT_O(pinh), .COMMIT_O(commit),
    .COMMIT_KIND_O(ckind), .COMMIT_ADDR_O(caddr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic int nbytes(input logic [7:0] op);
    case (op)
      8'h21, 8'hDC:        nbytes = 4;
      8'h20, 8'h52, 8'hD8: nbytes = a4 ? 4 : 3;
      default:             nbytes = 0;
    endcase
  endfunction : nbytes

  function automatic logic [2:0] ekind(input logic [7:0] op);
    case (op)
      8'h20, 8'h21: ekind = KIND_SECTOR;
      8'h52:        ekind = KIND_BLK32;
      8'hD8, 8'hDC: ekind = KIND_BLK64;
      8'h02:        ekind = KIND_PROG;
      default:      ekind = KIND_CHIP;
    endcase
  endfunction : ekind

  function automatic logic [31:0] eaddr(input logic [7:0] op, input logic [31:0] ad);
    logic [31:0] a;
    a = (nbytes(op) == 3) ? {8'h00, ad[23:0]} : ad;
    case (op)
      8'h20, 8'h21: eaddr = a & 32'hFFFF_F000;
      8'h52:        eaddr = a & 32'hFFFF_8000;
      8'hD8, 8'hDC: eaddr = a & 32'hFFFF_0000;
      default:      eaddr = 32'h0000_0000;
    endcase
  endfunction : eaddr

  task automatic cmd(input logic [7:0] op, input int n);
    logic [7:0] rx;
    u_host.frame({op, 56'h0}, n, rx);
  endtask : cmd

  // Write enable first, then the erase frame; extra bits break byte alignment
  task automatic erase(input logic [7:0] op, input logic [31:0] ad, input logic set_wel, input int extra);
    logic [7:0] rx;
    if (set_wel) begin
      @(negedge clk);
      wel_set = 1'b1;
      @(negedge clk);
      wel_set = 1'b0;
    end
    u_host.frame({op, (nbytes(op) == 3) ? {ad[23:0], 8'h00} : ad, 24'h0}, 8 + 8 * nbytes(op) + extra, rx);
  endtask : erase

  task automatic wait_commit(input logic [7:0] op, input logic [31:0] ad);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (commit !== 1'b1 && n < 3000);
    chk(commit, 1'b1);
    chk(ckind, ekind(op));
    chk(caddr, eaddr(op, ad));
  endtask : wait_commit

  task automatic wait_idle();
    for (int n = 0; n < 300 && busy !== 1'b0; n++) @(negedge clk);
  endtask : wait_idle

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    logic [31:0] ad;
    logic [7:0]  rx;
    int          n0;
    void'($urandom(32'h62921fae));
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    foreach (OPS[i]) begin
      ad = $urandom;
      a4 = 1'($urandom);
      erase(OPS[i], ad, 1'b1, 0);
      chk(busy, 1'b1);
      chk(ckd, ekind(OPS[i]));
      chk(cad, nbytes(OPS[i]) == 4 ? ad : (nbytes(OPS[i]) == 3 ? {8'h00, ad[23:0]} : 32'h0000_0000));
      wait_commit(OPS[i], ad);
      @(posedge clk);
      #1 chk(write_enable_latch, 1'b0);
    end
    $display("erase kinds done");
    a4 = 1'b0;
    for (int k = 0; k < 4; k++) begin
      tprot = (k == 1);
      aprot = (k == 2);
      erase(k == 2 ? 8'hC7 : (k == 3 ? 8'h52 : 8'h20), $urandom, k != 0, k == 3 ? 3 : 0);
      repeat (10) @(negedge clk);
      chk(busy, 1'b0);
      chk(write_enable_latch, k != 0);
    end
    tprot = 1'b0;
    aprot = 1'b0;
    $display("refusals done");
    ad = $urandom;
    erase(8'h20, ad, 1'b1, 0);
    u_host.frame({OP_READ_STATUS, 56'h0}, 16, rx);
    chk(rx, 8'h03);
    cmd(OP_SUSPEND, 8);
    chk(halt, 1'b1);
    wait_idle();
    chk(busy, 1'b0);
    chk(einh, 1'b1);
    u_host.frame({OP_READ_STATUS, 56'h0}, 16, rx);
    chk(rx, 8'h82);
    erase(8'h52, $urandom, 1'b1, 0);
    chk(busy, 1'b0);
    cmd(OP_RESUME, 8);
    chk(halt, 1'b0);
    repeat (2) @(negedge clk);
    chk(busy, 1'b1);
    repeat (200) @(negedge clk);
    cmd(OP_SUSPEND, 8);
    chk(halt, 1'b1);
    wait_idle();
    cmd(OP_RESUME, 8);
    wait_commit(8'h20, ad);
    erase(8'hC7, 32'h0000_0000, 1'b1, 0);
    cmd(OP_SUSPEND, 8);
    chk(halt, 1'b0);
    cmd(OP_RESUME, 8);
    chk(busy, 1'b1);
    wait_commit(8'hC7, 32'h0000_0000);
    @(negedge clk);
    wel_set = 1'b1;
    @(negedge clk);
    wel_set = 1'b0;
    prog    = 1'b1;
    @(negedge clk);
    prog    = 1'b0;
    cmd(OP_SUSPEND, 8);
    wait_idle();
    chk({pinh, einh, winh}, 3'h5);
    cmd(OP_RESUME, 8);
    wait_commit(8'h02, 32'h0000_0000);
    $display("suspend and resume done");
    erase(8'h20, $urandom, 1'b1, 0);
    cmd(OP_SUSPEND, 8);
    wait_idle();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(halt, 1'b0);
    cmd(OP_RESUME, 8);
    repeat (10) @(negedge clk);
    chk(busy, 1'b0);
    $display("power loss in suspend done");
    cmd(OP_POWER_DOWN, 9);
    chk(pd, 1'b0);
    cmd(OP_POWER_DOWN, 8);
    chk(pd, 1'b1);
    repeat (40) @(negedge clk);
    n0 = oe_cnt;
    u_host.frame({OP_READ_STATUS, 56'h0}, 16, rx);
    chk(oe_cnt - n0, 0);
    cmd(OP_RELEASE, 8);
    chk(pd, 1'b1);
    repeat (REST_CYC + 4) @(negedge clk);
    chk(pd, 1'b0);
    u_host.frame({OP_RELEASE, 56'h0}, 40, rx);
    chk(rx, DEVICE_ID);
    $display("power down done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
